// ===== pkg/ssr_pkg.sv
package ssr_pkg;

   // Core clock and serial link rate.
   localparam int unsigned CLK_HZ        = 40_000_000;
   localparam int unsigned BAUD          = 19200;
   localparam logic [11:0] BIT_CYC       = 12'(CLK_HZ / BAUD);
   localparam logic [11:0] HALF_BIT_CYC  = 12'(CLK_HZ / BAUD / 2);

   // Silence longer than the longest legal gap between bytes ends a frame.
   localparam int unsigned FRAME_GAP_MS  = 20;
   localparam int unsigned GAP_CYC_DFLT  = CLK_HZ / 1000 * FRAME_GAP_MS;

   // Holding register addresses.
   localparam logic [15:0] ADDR_SYS_ERR  = 16'h0007;
   localparam logic [15:0] ADDR_HEALTH   = 16'h0009;
   localparam logic [15:0] ADDR_SPEED    = 16'h000a;
   localparam logic [15:0] ADDR_SENSE    = 16'h000b;
   localparam logic [15:0] ADDR_CURRENT  = 16'h000c;
   localparam logic [15:0] ADDR_BATTERY  = 16'h000d;
   localparam logic [15:0] ADDR_INAMP    = 16'h000e;
   localparam logic [15:0] RESET_VALUE   = 16'h0000;

   // Error flag bit positions.
   localparam int unsigned ERR_GPS_BIT    = 0;
   localparam int unsigned ERR_CHARGE_BIT = 1;
   localparam int unsigned ERR_MOTOR_BIT  = 2;
   localparam int unsigned ERR_ANALOG_BIT = 3;

   // Health indicator codes.
   localparam logic [15:0] HC_HEALTHY    = 16'h0000;
   localparam logic [15:0] HC_JAM        = 16'h0001;
   localparam logic [15:0] HC_SUPPLY36   = 16'h0002;
   localparam logic [15:0] HC_MOTOR_COMM = 16'h0003;
   localparam logic [15:0] HC_CHG_COMM   = 16'h0004;
   localparam logic [15:0] HC_BATT_LIMIT = 16'h0005;
   localparam logic [15:0] HC_MOTOR_HIGH = 16'h0010;
   localparam logic [15:0] HC_BATT_LOW   = 16'h0020;
   localparam logic [15:0] HC_TEMP       = 16'h0030;
   localparam logic [15:0] HC_SUPPLY5    = 16'h0040;
   localparam logic [15:0] HC_GPS_COMM   = 16'h0050;
   localparam logic [15:0] HC_ACQUIRING  = 16'h0100;

   // Protocol constants.
   localparam logic [7:0]  FUNC_READ_HOLD = 8'h03;
   localparam logic [7:0]  FUNC_EXC_FLAG  = 8'h80;
   localparam logic [7:0]  EXC_FUNCTION   = 8'h01;
   localparam logic [7:0]  EXC_ADDRESS    = 8'h02;
   localparam logic [7:0]  EXC_COUNT      = 8'h03;
   localparam logic [15:0] MAX_COUNT      = 16'h007d;
   localparam logic [3:0]  REQ_LEN        = 4'h8;
   localparam logic [3:0]  MIN_LEN        = 4'h4;
   localparam logic [7:0]  HDR_LEN        = 8'h03;
   localparam logic [15:0] CRC_INIT       = 16'hffff;
   localparam logic [15:0] CRC_POLY       = 16'ha001;

   typedef enum logic [1:0]
   {
      S_IDLE   = 2'b00,
      S_SEND   = 2'b01,
      S_CRC_LO = 2'b10,
      S_CRC_HI = 2'b11
   } ssr_state_type;

endpackage

// ===== hw/ssr_crc16.sv
`timescale 1ns/10ps
// Folds one byte into a running reflected CRC-16 in a single cycle.
module ssr_crc16
(
   input  wire logic [15:0] crc_in,
   input  wire logic [7:0]  data,
   output logic      [15:0] crc_out
);

   always_comb
   begin
      crc_out = crc_in ^ {8'h00, data};
      for (int i = 0; i < 8; i++)
      begin
         if (crc_out[0])
            crc_out = (crc_out >> 1) ^ ssr_pkg::CRC_POLY;
         else
            crc_out = crc_out >> 1;
      end
   end

endmodule

// ===== hw/ssr_uart.sv
`timescale 1ns/10ps
// Byte serialiser and deserialiser, 8 data bits, no parity, one stop bit.
module ssr_uart
(
   input  wire logic       clk,
   input  wire logic       rstn,
   input  wire logic       rxd,
   output logic            txd,
   output logic [7:0]      rx_data,
   output logic            rx_valid,
   input  wire logic [7:0] tx_data,
   input  wire logic       tx_start,
   output logic            tx_busy
);

   logic        rxd_meta_r;
   logic        rxd_sync_r;
   logic        rx_busy_r;
   logic [11:0] rx_cnt_r;
   logic [3:0]  rx_bit_r;
   logic [11:0] tx_cnt_r;
   logic [3:0]  tx_bit_r;
   logic [8:0]  tx_shift_r;

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rxd_meta_r <= 1'b1;
         rxd_sync_r <= 1'b1;
      end
      else
      begin
         rxd_meta_r <= rxd;
         rxd_sync_r <= rxd_meta_r;
      end
   end

   // Bits are sampled mid-cell; a start bit gone high at mid-cell is noise.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rx_busy_r <= 1'b0;
         rx_cnt_r  <= 12'h000;
         rx_bit_r  <= 4'h0;
         rx_data   <= 8'h00;
         rx_valid  <= 1'b0;
      end
      else
      begin
         rx_valid <= 1'b0;
         if (!rx_busy_r)
         begin
            if (!rxd_sync_r)
            begin
               rx_busy_r <= 1'b1;
               rx_cnt_r  <= ssr_pkg::HALF_BIT_CYC;
               rx_bit_r  <= 4'h0;
            end
         end
         else if (rx_cnt_r != 12'h000)
            rx_cnt_r <= rx_cnt_r - 12'h001;
         else
         begin
            rx_cnt_r <= ssr_pkg::BIT_CYC - 12'h001;
            if (rx_bit_r == 4'h0)
            begin
               rx_busy_r <= !rxd_sync_r;
               rx_bit_r  <= 4'h1;
            end
            else if (rx_bit_r <= 4'h8)
            begin
               rx_data  <= {rxd_sync_r, rx_data[7:1]};
               rx_bit_r <= rx_bit_r + 4'h1;
            end
            else
            begin
               rx_busy_r <= 1'b0;
               rx_valid  <= rxd_sync_r;
            end
         end
      end
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         txd        <= 1'b1;
         tx_busy    <= 1'b0;
         tx_cnt_r   <= 12'h000;
         tx_bit_r   <= 4'h0;
         tx_shift_r <= 9'h1ff;
      end
      else if (!tx_busy)
      begin
         if (tx_start)
         begin
            txd        <= 1'b0;
            tx_busy    <= 1'b1;
            tx_cnt_r   <= ssr_pkg::BIT_CYC - 12'h001;
            tx_bit_r   <= 4'h0;
            tx_shift_r <= {1'b1, tx_data};
         end
      end
      else if (tx_cnt_r != 12'h000)
         tx_cnt_r <= tx_cnt_r - 12'h001;
      else if (tx_bit_r == 4'h9)
         tx_busy <= 1'b0;
      else
      begin
         txd        <= tx_shift_r[0];
         tx_shift_r <= {1'b1, tx_shift_r[8:1]};
         tx_bit_r   <= tx_bit_r + 4'h1;
         tx_cnt_r   <= ssr_pkg::BIT_CYC - 12'h001;
      end
   end

endmodule

// ===== hw/ssr_top.sv
`timescale 1ns/10ps
module ssr_top
#(
   parameter logic [7:0]  SLAVE_ID = 8'h01, // Arbitrary default station id.
   parameter int unsigned GAP_CYC  = ssr_pkg::GAP_CYC_DFLT
)
(
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic        rxd,
   output logic             txd,
   input  wire logic        gps_comm_lost,
   input  wire logic        charger_comm_lost,
   input  wire logic        motor_comm_lost,
   input  wire logic        analog_limit_violation,
   input  wire logic        motor_sample_valid,
   input  wire logic [15:0] motor_speed_in,
   input  wire logic [15:0] motor_sense_in,
   input  wire logic [15:0] motor_current_in,
   input  wire logic        charger_sample_valid,
   input  wire logic [15:0] battery_in,
   input  wire logic [15:0] input_current_in,
   input  wire logic        battery_low_limit,
   input  wire logic        jam_recovery_sequence,
   input  wire logic        supply36_out_of_range,
   input  wire logic        motor_current_high,
   input  wire logic        battery_low,
   input  wire logic        temperature_out_of_range,
   input  wire logic        supply5_out_of_range,
   input  wire logic        acquiring_fix
);

   logic [7:0]            rx_data;
   logic                  rx_valid;
   logic                  tx_busy;
   logic [7:0]            tx_byte_r;
   logic                  tx_go_r;
   logic [15:0]           err_r;
   logic [15:0]           health_r;
   logic [15:0]           speed_r;
   logic [15:0]           sense_r;
   logic [15:0]           cur_r;
   logic [15:0]           batt_r;
   logic [15:0]           inamp_r;
   logic [7:0]            req_r [0:7];
   logic [3:0]            len_r;
   logic [15:0]           crc_rx_r;
   logic [15:0]           crc_rx_nxt;
   logic [19:0]           gap_r;
   logic                  frame_end;
   ssr_pkg::ssr_state_type state_r;
   logic [7:0]            idx_r;
   logic [7:0]            plen_r;
   logic                  exc_r;
   logic [7:0]            func_r;
   logic [7:0]            exc_code_r;
   logic [15:0]           start_r;
   logic [7:0]            cnt_r;
   logic [15:0]           crc_tx_r;
   logic [15:0]           crc_tx_nxt;
   logic [7:0]            byte_now;
   logic                  can_send;
   logic [15:0]           req_start;
   logic [15:0]           req_count;
   logic                  req_hit;
   logic                  accept;
   logic [7:0]            word_off;
   logic [15:0]           word_now;

   ssr_uart u_uart
   (
      .clk      (clk),
      .rstn     (rstn),
      .rxd      (rxd),
      .txd      (txd),
      .rx_data  (rx_data),
      .rx_valid (rx_valid),
      .tx_data  (tx_byte_r),
      .tx_start (tx_go_r),
      .tx_busy  (tx_busy)
   );

   ssr_crc16 u_crc_rx
   (
      .crc_in  (crc_rx_r),
      .data    (rx_data),
      .crc_out (crc_rx_nxt)
   );

   ssr_crc16 u_crc_tx
   (
      .crc_in  (crc_tx_r),
      .data    (byte_now),
      .crc_out (crc_tx_nxt)
   );

   function automatic logic [15:0] reg_value(input logic [15:0] a);
      case (a)
         ssr_pkg::ADDR_SYS_ERR: reg_value = err_r;
         ssr_pkg::ADDR_HEALTH:  reg_value = health_r;
         ssr_pkg::ADDR_SPEED:   reg_value = speed_r;
         ssr_pkg::ADDR_SENSE:   reg_value = sense_r;
         ssr_pkg::ADDR_CURRENT: reg_value = cur_r;
         ssr_pkg::ADDR_BATTERY: reg_value = batt_r;
         ssr_pkg::ADDR_INAMP:   reg_value = inamp_r;
         default:               reg_value = ssr_pkg::RESET_VALUE;
      endcase
   endfunction

   // Address 8 is a hole, so a block either is the error word alone or
   // lies wholly within the indicator and measurement words.
   function automatic logic range_ok(input logic [15:0] s,
                                     input logic [15:0] n);
      logic [16:0] last;
      last = {1'b0, s} + {1'b0, n} - 17'h00001;
      range_ok = (s == ssr_pkg::ADDR_SYS_ERR && n == 16'h0001) ||
                 (s >= ssr_pkg::ADDR_HEALTH &&
                  last <= {1'b0, ssr_pkg::ADDR_INAMP});
   endfunction

   function automatic logic [15:0] health_code(input logic [10:0] f);
      if (f[0])
         health_code = ssr_pkg::HC_BATT_LIMIT;
      else if (f[1])
         health_code = ssr_pkg::HC_JAM;
      else if (f[2])
         health_code = ssr_pkg::HC_SUPPLY36;
      else if (f[3])
         health_code = ssr_pkg::HC_MOTOR_COMM;
      else if (f[4])
         health_code = ssr_pkg::HC_CHG_COMM;
      else if (f[5])
         health_code = ssr_pkg::HC_MOTOR_HIGH;
      else if (f[6])
         health_code = ssr_pkg::HC_BATT_LOW;
      else if (f[7])
         health_code = ssr_pkg::HC_TEMP;
      else if (f[8])
         health_code = ssr_pkg::HC_SUPPLY5;
      else if (f[9])
         health_code = ssr_pkg::HC_GPS_COMM;
      else if (f[10])
         health_code = ssr_pkg::HC_ACQUIRING;
      else
         health_code = ssr_pkg::HC_HEALTHY;
   endfunction

   // Flags are live levels; there is nothing to clear.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         err_r <= ssr_pkg::RESET_VALUE;
      else
      begin
         err_r                          <= 16'h0000;
         err_r[ssr_pkg::ERR_GPS_BIT]    <= gps_comm_lost;
         err_r[ssr_pkg::ERR_CHARGE_BIT] <= charger_comm_lost;
         err_r[ssr_pkg::ERR_MOTOR_BIT]  <= motor_comm_lost;
         err_r[ssr_pkg::ERR_ANALOG_BIT] <= analog_limit_violation;
      end
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         health_r <= ssr_pkg::HC_HEALTHY;
      else
         health_r <= health_code({acquiring_fix, gps_comm_lost,
                                  supply5_out_of_range,
                                  temperature_out_of_range, battery_low,
                                  motor_current_high, charger_comm_lost,
                                  motor_comm_lost, supply36_out_of_range,
                                  jam_recovery_sequence, battery_low_limit});
   end

   // Samples from a module whose link is lost are refused, so the master
   // keeps seeing the last good values.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         speed_r <= ssr_pkg::RESET_VALUE;
         sense_r <= ssr_pkg::RESET_VALUE;
         cur_r   <= ssr_pkg::RESET_VALUE;
      end
      else if (motor_sample_valid && !motor_comm_lost)
      begin
         speed_r <= motor_speed_in;
         sense_r <= motor_sense_in;
         cur_r   <= motor_current_in;
      end
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         batt_r  <= ssr_pkg::RESET_VALUE;
         inamp_r <= ssr_pkg::RESET_VALUE;
      end
      else if (charger_sample_valid && !charger_comm_lost)
      begin
         batt_r  <= battery_in;
         inamp_r <= input_current_in;
      end
   end

   assign frame_end = (len_r != 4'h0) && !rx_valid &&
                      (gap_r == 20'(GAP_CYC - 1));

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         gap_r <= 20'h00000;
      else if (rx_valid)
         gap_r <= 20'h00000;
      else if (len_r != 4'h0 && gap_r != 20'(GAP_CYC - 1))
         gap_r <= gap_r + 20'h00001;
   end

   // Only the first eight bytes are kept; a longer frame saturates the
   // length at nine and can never match a request.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         len_r    <= 4'h0;
         crc_rx_r <= ssr_pkg::CRC_INIT;
         for (int i = 0; i < 8; i++)
            req_r[i] <= 8'h00;
      end
      else if (frame_end)
      begin
         len_r    <= 4'h0;
         crc_rx_r <= ssr_pkg::CRC_INIT;
      end
      else if (rx_valid)
      begin
         if (len_r < ssr_pkg::REQ_LEN)
            req_r[len_r[2:0]] <= rx_data;
         if (len_r <= ssr_pkg::REQ_LEN)
            len_r <= len_r + 4'h1;
         crc_rx_r <= crc_rx_nxt;
      end
   end

   assign req_start = {req_r[2], req_r[3]};
   assign req_count = {req_r[4], req_r[5]};
   assign req_hit   = frame_end && state_r == ssr_pkg::S_IDLE &&
                      crc_rx_r == 16'h0000 && req_r[0] == SLAVE_ID &&
                      len_r >= ssr_pkg::MIN_LEN && len_r <= ssr_pkg::REQ_LEN;
   assign accept    = req_hit && (req_r[1] != ssr_pkg::FUNC_READ_HOLD ||
                                  len_r == ssr_pkg::REQ_LEN);
   assign can_send  = state_r != ssr_pkg::S_IDLE && !tx_busy && !tx_go_r;
   assign word_off  = (idx_r - ssr_pkg::HDR_LEN) >> 1;

   always_comb
   begin
      byte_now = 8'h00;
      word_now = reg_value(start_r + {8'h00, word_off});
      unique case (state_r)
         ssr_pkg::S_IDLE:
            byte_now = 8'h00;
         ssr_pkg::S_SEND:
            if (idx_r == 8'h00)
               byte_now = SLAVE_ID;
            else if (idx_r == 8'h01)
               byte_now = func_r;
            else if (idx_r == 8'h02)
               byte_now = exc_r ? exc_code_r : 8'(cnt_r << 1);
            else if (idx_r[0])
               byte_now = word_now[15:8];
            else
               byte_now = word_now[7:0];
         ssr_pkg::S_CRC_LO:
            byte_now = crc_tx_r[7:0];
         ssr_pkg::S_CRC_HI:
            byte_now = crc_tx_r[15:8];
      endcase
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         tx_go_r   <= 1'b0;
         tx_byte_r <= 8'h00;
      end
      else
      begin
         tx_go_r <= can_send;
         if (can_send)
            tx_byte_r <= byte_now;
      end
   end

   // Requests that end while a reply is still going out are dropped;
   // masters must poll one at a time.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state_r    <= ssr_pkg::S_IDLE;
         idx_r      <= 8'h00;
         plen_r     <= 8'h00;
         exc_r      <= 1'b0;
         func_r     <= 8'h00;
         exc_code_r <= 8'h00;
         start_r    <= 16'h0000;
         cnt_r      <= 8'h00;
         crc_tx_r   <= ssr_pkg::CRC_INIT;
      end
      else
      begin
         unique case (state_r)
            ssr_pkg::S_IDLE:
               if (accept)
               begin
                  state_r  <= ssr_pkg::S_SEND;
                  idx_r    <= 8'h00;
                  crc_tx_r <= ssr_pkg::CRC_INIT;
                  start_r  <= req_start;
                  cnt_r    <= req_count[7:0];
                  func_r   <= req_r[1];
                  exc_r    <= 1'b1;
                  plen_r   <= ssr_pkg::HDR_LEN;
                  if (req_r[1] != ssr_pkg::FUNC_READ_HOLD)
                  begin
                     func_r     <= req_r[1] | ssr_pkg::FUNC_EXC_FLAG;
                     exc_code_r <= ssr_pkg::EXC_FUNCTION;
                  end
                  else if (req_count == 16'h0000 ||
                           req_count > ssr_pkg::MAX_COUNT)
                  begin
                     func_r     <= req_r[1] | ssr_pkg::FUNC_EXC_FLAG;
                     exc_code_r <= ssr_pkg::EXC_COUNT;
                  end
                  else if (!range_ok(req_start, req_count))
                  begin
                     func_r     <= req_r[1] | ssr_pkg::FUNC_EXC_FLAG;
                     exc_code_r <= ssr_pkg::EXC_ADDRESS;
                  end
                  else
                  begin
                     exc_r  <= 1'b0;
                     plen_r <= ssr_pkg::HDR_LEN + 8'(req_count << 1);
                  end
               end
            ssr_pkg::S_SEND:
               if (can_send)
               begin
                  idx_r    <= idx_r + 8'h01;
                  crc_tx_r <= crc_tx_nxt;
                  if (idx_r == plen_r - 8'h01)
                     state_r <= ssr_pkg::S_CRC_LO;
               end
            ssr_pkg::S_CRC_LO:
               if (can_send)
                  state_r <= ssr_pkg::S_CRC_HI;
            ssr_pkg::S_CRC_HI:
               if (can_send)
                  state_r <= ssr_pkg::S_IDLE;
         endcase
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   a_err_upper_zero: assert property (err_r[15:4] == 12'h000)
      else $error("Error register upper bits not zero.");
   a_err_all_clear: assert property (!gps_comm_lost && !charger_comm_lost &&
      !motor_comm_lost && !analog_limit_violation |=> err_r == 16'h0000)
      else $error("Error register nonzero while all healthy.");
   a_err_gps_bit: assert property (gps_comm_lost |=> err_r[0])
      else $error("Positioning link loss not flagged.");
   a_err_charge_bit: assert property (charger_comm_lost |=> err_r[1])
      else $error("Charger link loss not flagged.");
   a_err_motor_bit: assert property (motor_comm_lost |=> err_r[2])
      else $error("Motor link loss not flagged.");
   a_err_analog_bit: assert property (analog_limit_violation |=> err_r[3])
      else $error("Analog limit violation not flagged.");
   a_err_all_fifteen: assert property (gps_comm_lost && charger_comm_lost &&
      motor_comm_lost && analog_limit_violation |=> err_r == 16'h000f)
      else $error("All errors do not give fifteen.");
   a_hold_on_loss: assert property (motor_comm_lost |=> $stable(speed_r))
      else $error("Motor values changed while link lost.");
   a_speed_track: assert property (motor_sample_valid && !motor_comm_lost
      |=> speed_r == $past(motor_speed_in))
      else $error("Speed register missed a sample.");
   a_health_jam: assert property (jam_recovery_sequence &&
      !battery_low_limit |=> health_r == 16'h0001)
      else $error("Jam recovery code wrong.");
   a_health_gps: assert property (gps_comm_lost && !battery_low_limit &&
      !jam_recovery_sequence && !supply36_out_of_range && !motor_comm_lost &&
      !charger_comm_lost && !motor_current_high && !battery_low &&
      !temperature_out_of_range && !supply5_out_of_range
      |=> health_r == 16'h0050)
      else $error("Positioning fault code wrong.");
   a_reply_starts: assert property (accept |=> state_r == ssr_pkg::S_SEND
      ##[1:4] tx_go_r && tx_byte_r == SLAVE_ID)
      else $error("Accepted request not answered.");
   a_reply_func: assert property (can_send && state_r == ssr_pkg::S_SEND &&
      idx_r == 8'h01 && !exc_r |=> tx_byte_r == 8'h03)
      else $error("Reply function code wrong.");

   c_normal_reply: cover property (accept && req_r[1] == 8'h03 &&
      range_ok(req_start, req_count));
   c_exception_reply: cover property (state_r == ssr_pkg::S_SEND && exc_r);
   c_all_errors: cover property (err_r == 16'h000f);
   c_reply_done: cover property (state_r == ssr_pkg::S_CRC_HI && can_send);

endmodule

// ===== test/ssr_master_model.sv
`timescale 1ns/10ps
// Serial master: sends one read request, then collects the whole reply.
module ssr_master_model
(
   input  wire logic clk,
   output logic      rxd,
   input  wire logic txd
);
   logic [7:0] m [0:19];
   initial rxd = 1'b1;
   function automatic logic [15:0] crc(input int n);
      logic [15:0] c;
      c = 16'hffff;
      for (int i = 0; i < n; i++)
      begin
         c = c ^ {8'h00, m[i]};
         for (int k = 0; k < 8; k++)
            c = c[0] ? (c >> 1) ^ ssr_pkg::CRC_POLY : c >> 1;
      end
      return c;
   endfunction
   // Bytes go back to back; it takes 25000 idle cycles, about twelve bits, after a stop bit to close the frame.
   // An exception reply is five bytes long whatever count was asked for.
   task automatic xfer(input logic [7:0] a, input logic [7:0] n,
                       input logic x,
                       output logic [7:0] r [0:19], output logic ok);
      logic [15:0] c;
      int          t;
      int          k;
      k = x ? 5 : 2 * n + 5;
      {m[0], m[1], m[2], m[3], m[4], m[5]} =
         {8'h01, ssr_pkg::FUNC_READ_HOLD, 8'h00, a, 8'h00, n};
      c = crc(6);
      m[6] = c[7:0];
      m[7] = c[15:8];
      for (int j = 0; j < 80; j++)
      begin
         rxd <= (j % 10 == 0) ? 1'b0 : (j % 10 == 9) ? 1'b1
                : m[j / 10][(j % 10 + 7) % 8];
         repeat (ssr_pkg::BIT_CYC) @(posedge clk);
      end
      for (int b = 0; b < k; b++)
      begin
         t = 0;
         while (txd !== 1'b0 && t < 90000)
         begin
            @(posedge clk);
            t++;
         end
         repeat (ssr_pkg::HALF_BIT_CYC) @(posedge clk);
         for (int i = 0; i < 8; i++)
         begin
            repeat (ssr_pkg::BIT_CYC) @(posedge clk);
            m[b] = {txd, m[b][7:1]};
         end
         repeat (ssr_pkg::BIT_CYC) @(posedge clk);
      end
      c = crc(k - 2);
      ok = ({m[k - 1], m[k - 2]} === c);
      r = m;
   endtask
endmodule

// ===== test/tb_top.sv
`timescale 1ns/10ps
`define CHK(what, e, g) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
   $display("mismatch %s expected %h seen %h", what, e, g); end end
module tb_top;
   logic        clk;
   logic        rstn;
   logic        rxd;
   logic        txd;
   logic [3:0]  lost;
   logic [7:0]  hl;
   logic        mv;
   logic        cv;
   logic [15:0] w [0:4];
   logic [95:0] got;
   logic [79:0] old;
   int          n_errors;
   int          n_tests;
   int          cyc = 0;
   ssr_top #(.SLAVE_ID(8'h01), .GAP_CYC(25000)) i_ssr_top
   (
      .clk(clk), .rstn(rstn), .rxd(rxd), .txd(txd),
      .gps_comm_lost(lost[0]), .charger_comm_lost(lost[1]),
      .motor_comm_lost(lost[2]), .analog_limit_violation(lost[3]),
      .motor_sample_valid(mv), .motor_speed_in(w[0]),
      .motor_sense_in(w[1]), .motor_current_in(w[2]),
      .charger_sample_valid(cv), .battery_in(w[3]),
      .input_current_in(w[4]), .battery_low_limit(hl[0]),
      .jam_recovery_sequence(hl[1]), .supply36_out_of_range(hl[2]),
      .motor_current_high(hl[3]), .battery_low(hl[4]),
      .temperature_out_of_range(hl[5]), .supply5_out_of_range(hl[6]),
      .acquiring_fix(hl[7])
   );
   ssr_master_model i_ssr_master_model
   (
      .clk(clk), .rxd(rxd), .txd(txd)
   );
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // The frame gap counts from each stop bit, so it must outlast a byte.
   task automatic rd(input logic [7:0] a, input logic [7:0] n,
                     input logic x);
      logic [7:0]  r [0:19];
      logic        ok;
      logic [23:0] hd;
      i_ssr_master_model.xfer(a, n, x, r, ok);
      got = '0;
      for (int i = 0; i < n; i++)
         got = {got[79:0], r[3 + 2 * i], r[4 + 2 * i]};
      hd = {8'h01, ssr_pkg::FUNC_READ_HOLD, 8'(2 * n)};
      if (x)
         hd = {8'h01, ssr_pkg::FUNC_READ_HOLD | ssr_pkg::FUNC_EXC_FLAG,
               ssr_pkg::EXC_ADDRESS};
      `CHK("head", hd, {r[0], r[1], r[2]})
      `CHK("crc", 1'b1, ok)
   endtask
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 3000000)
      begin
         n_errors++;
         $display("mismatch run length expected end seen hang");
         give_verdict();
      end
   end
   initial
   begin
      {rstn, lost, hl, mv, cv} = '0;
      w = '{16'h2ee0, 16'h0001, 16'h0dac, 16'h0082, 16'h0019};
      n_errors = 0;
      n_tests = 0;
      repeat (16) @(posedge clk);
      {rstn, mv, cv, hl} <= {3'b111, 8'h10};
      @(posedge clk);
      {mv, cv} <= 2'b00;
      rd(8'h07, 8'h01, 1'b0);
      `CHK("errors", 16'h0000, got[15:0])
      rd(8'h09, 8'h06, 1'b0);
      old = {w[0], w[1], w[2], w[3], w[4]};
      `CHK("regs", {16'h0020, old}, got)
      $display("test healthy done");
      {lost, hl, mv, cv} <= {4'hf, 8'h00, 2'b11};
      w <= '{16'h1111, 16'h0000, 16'h2222, 16'h0033, 16'h0044};
      @(posedge clk);
      {mv, cv} <= 2'b00;
      rd(8'h07, 8'h01, 1'b0);
      `CHK("errors", 16'h000f, got[15:0])
      rd(8'h09, 8'h06, 1'b0);
      `CHK("held regs", {16'h0003, old}, got)
      $display("test all lost done");
      lost <= 4'h9;
      rd(8'h07, 8'h01, 1'b0);
      `CHK("errors", 16'h0009, got[15:0])
      $display("test partial done");
      hl <= 8'h02;
      rd(8'h08, 8'h01, 1'b1);
      $display("test exception done");
      give_verdict();
   end
endmodule
